/* design/rtc_osc_pkg.sv */
// constants and types shared by the oscillator control and status block
package rtc_osc_pkg;

   // =========================================================
   // types
   typedef logic [31:0] word_type;
   typedef logic [7:0] byte_type;
   typedef logic [3:0] cap_code_type;

   // =========================================================
   // register indexes; byte address is four times the index
   localparam logic [5:0] IDX_CAPTURE0 = 6'h00;
   localparam logic [5:0] IDX_CAPTURE3 = 6'h03;
   localparam logic [5:0] IDX_CONTROL = 6'h04;
   localparam logic [5:0] IDX_OSC_CONTROL = 6'h05;
   localparam logic [5:0] IDX_OSC_LOAD_CONFIG = 6'h06;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
   localparam logic [5:0] IDX_IRQ_ENABLE = 6'h11;
   localparam logic [5:0] IDX_IRQ_CLEAR = 6'h12;

   // =========================================================
   // control register fields
   localparam int CTL_CAPTURE_BIT = 0;
   localparam int CTL_SET_BIT = 1;
   localparam int CTL_ALARM_BIT = 2;

   // oscillator control fields
   localparam int OSC_GAIN_BIT = 7;
   localparam int OSC_CRYSTAL_BIT = 6;
   localparam int OSC_BIAS_BIT = 5;
   localparam int OSC_VALID_BIT = 4;

   // load configuration fields
   localparam int CFG_STEP_BIT = 7;
   localparam int CFG_READY_BIT = 6;
   localparam int CFG_CODE_LSB = 0;

   // interrupt status fields
   localparam int IRQ_ALARM_BIT = 0;
   localparam int IRQ_SET_DONE_BIT = 1;
   localparam int IRQ_CAP_DONE_BIT = 2;
   localparam int IRQ_CAP_READY_BIT = 3;
   localparam int IRQ_WIDTH = 4;

   // =========================================================
   // values after reset
   localparam logic OSC_FIELD_RESET = 1'b0;
   localparam logic CFG_STEP_RESET = 1'b0;
   localparam cap_code_type CAP_CODE_RESET = 4'h8;
   localparam word_type COUNTER_RESET = 32'h0000_0000;
   localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 4'h0;

   // timer operation states
   typedef enum logic [2:0] {
      OP_IDLE = 3'b001,
      OP_SET = 3'b010,
      OP_CAPTURE = 3'b100
   } op_state_type;

endpackage

/* design/cap_step_if.sv */
// signals between the register file and the load capacitance stepper
`timescale 1ns/1ps
`default_nettype none
interface cap_step_if;
   logic step_enable;
   logic [3:0] target_code;
   logic rtc_tick;
   logic [3:0] applied_code;
   logic ready;

   modport ctrl (output step_enable, output target_code, output rtc_tick,
      input applied_code, input ready);
   modport stepper (input step_enable, input target_code, input rtc_tick,
      output applied_code, output ready);
endinterface
`default_nettype wire

/* design/pin_sync.sv */
// three-stage synchroniser for one pin, with agreed level and rising pulse
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // =========================================================
   // stages; s1 feeds only s2
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a change counts only once the last two stages agree
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         level_o <= 1'b0;
      end else if (s2_reg == s3_reg) begin
         level_o <= s3_reg;
      end
   end

   assign rise_o = (s2_reg == s3_reg) && s3_reg && !level_o;
endmodule
`default_nettype wire

/* design/cap_stepper.sv */
// moves the applied load capacitance code toward the programmed target
`timescale 1ns/1ps
`default_nettype none
module cap_stepper (
   input wire logic clk_i,
   input wire logic reset_n_i,
   cap_step_if.stepper bus
);
   import rtc_osc_pkg::*;

   cap_code_type applied_reg;

   // =========================================================
   // one step per oscillator cycle, or straight to target
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         applied_reg <= CAP_CODE_RESET;
      end else if (!bus.step_enable) begin
         applied_reg <= bus.target_code;
      end else if (bus.rtc_tick && applied_reg < bus.target_code) begin
         applied_reg <= applied_reg + 4'h1;
      end else if (bus.rtc_tick && applied_reg > bus.target_code) begin
         applied_reg <= applied_reg - 4'h1;
      end
   end

   assign bus.applied_code = applied_reg;
   assign bus.ready = (applied_reg == bus.target_code);
endmodule
`default_nettype wire

/* design/rtc_osc_control_status.sv */
// real-time clock oscillator control and status with timer set and capture
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rtc_osc_control_status (
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   input wire logic [7:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire rtc_osc_pkg::word_type AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output rtc_osc_pkg::word_type AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   input wire logic RTC_CLK_I,
   input wire logic ALARM_MATCH_I,
   input wire logic AMP_VALID_I,
   output logic GAIN_CONTROL_ENABLE_O,
   output logic CRYSTAL_MODE_SELECT_O,
   output logic BIAS_DOUBLE_ENABLE_O,
   output rtc_osc_pkg::cap_code_type LOAD_CAP_CODE_O,
   output rtc_osc_pkg::word_type COUNTER_O,
   output logic IRQ_O
);
   import rtc_osc_pkg::*;

   // =========================================================
   // declarations
   logic rtc_tick;
   logic alarm_rise;
   logic amp_valid;
   logic ack_reg;
   logic [5:0] index;
   logic wr_en;
   byte_type wr_byte;
   word_type rd_next;
   word_type rd_reg;
   logic alarm_flag_reg;
   logic auto_reset_reg;
   logic set_req_reg;
   logic cap_req_reg;
   op_state_type op_reg;
   logic set_done;
   logic cap_done;
   word_type counter_reg;
   byte_type capture_reg [0:3];
   logic gain_reg;
   logic crystal_reg;
   logic bias_reg;
   logic step_en_reg;
   cap_code_type target_reg;
   logic ready_prev_reg;
   logic [IRQ_WIDTH-1:0] irq_status_reg;
   logic [IRQ_WIDTH-1:0] irq_enable_reg;
   logic [IRQ_WIDTH-1:0] irq_event;
   logic [IRQ_WIDTH-1:0] irq_clear;

   cap_step_if cap_bus ();

   // =========================================================
   // pin synchronisers; the oscillator clock is sampled as a tick
   pin_sync u_tick_sync (
      .clk_i(CORE_CLK_I),
      .reset_n_i(RESET_N_I),
      .pin_i(RTC_CLK_I),
      .level_o(),
      .rise_o(rtc_tick)
   );

   pin_sync u_alarm_sync (
      .clk_i(CORE_CLK_I),
      .reset_n_i(RESET_N_I),
      .pin_i(ALARM_MATCH_I),
      .level_o(),
      .rise_o(alarm_rise)
   );

   pin_sync u_valid_sync (
      .clk_i(CORE_CLK_I),
      .reset_n_i(RESET_N_I),
      .pin_i(AMP_VALID_I),
      .level_o(amp_valid),
      .rise_o()
   );

   // =========================================================
   // bus slave: one wait cycle, then the access completes
   function automatic logic [5:0] reg_index(input logic [7:0] addr);
      reg_index = addr[7:2];
   endfunction

   assign index = reg_index(AVS_ADDRESS_I);
   assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack_reg;
   assign wr_en = AVS_WRITE_I && ack_reg && AVS_BYTEENABLE_I[0];
   assign wr_byte = AVS_WRITEDATA_I[7:0];
   assign AVS_READDATA_O = rd_reg;

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (AVS_READ_I || AVS_WRITE_I) && !ack_reg;
      end
   end

   // read data is frozen in the wait cycle so it stands while the master samples
   always_comb begin
      rd_next = 32'h0000_0000;
      case (index)
         IDX_CONTROL: begin
            rd_next[CTL_ALARM_BIT] = alarm_flag_reg;
            rd_next[CTL_SET_BIT] = set_req_reg;
            rd_next[CTL_CAPTURE_BIT] = cap_req_reg;
         end
         IDX_OSC_CONTROL: begin
            rd_next[OSC_GAIN_BIT] = gain_reg;
            rd_next[OSC_CRYSTAL_BIT] = crystal_reg;
            rd_next[OSC_BIAS_BIT] = bias_reg;
            rd_next[OSC_VALID_BIT] = amp_valid;
         end
         IDX_OSC_LOAD_CONFIG: begin
            rd_next[CFG_STEP_BIT] = step_en_reg;
            rd_next[CFG_READY_BIT] = cap_bus.ready;
            rd_next[CFG_CODE_LSB +: 4] = target_reg;
         end
         IDX_IRQ_STATUS: begin
            rd_next[IRQ_WIDTH-1:0] = irq_status_reg;
         end
         IDX_IRQ_ENABLE: begin
            rd_next[IRQ_WIDTH-1:0] = irq_enable_reg;
         end
         default: begin
            if (index <= IDX_CAPTURE3) begin
               rd_next[7:0] = capture_reg[index[1:0]];
            end
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rd_reg <= 32'h0000_0000;
      end else if (AVS_READ_I && !ack_reg) begin
         rd_reg <= rd_next;
      end
   end

   // =========================================================
   // alarm flag and auto reset
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         alarm_flag_reg <= 1'b0;
      end else if (alarm_rise) begin
         alarm_flag_reg <= 1'b1;
      end else if (rtc_tick) begin
         alarm_flag_reg <= 1'b0;
      end
   end

   // a write to bit 2 never touches the flag itself
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         auto_reset_reg <= 1'b0;
      end else if (wr_en && index == IDX_CONTROL) begin
         auto_reset_reg <= wr_byte[CTL_ALARM_BIT];
      end
   end

   // =========================================================
   // timer set and capture requests
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         set_req_reg <= 1'b0;
         cap_req_reg <= 1'b0;
      end else begin
         if (wr_en && index == IDX_CONTROL && wr_byte[CTL_SET_BIT]) begin
            set_req_reg <= 1'b1;
         end else if (set_done) begin
            set_req_reg <= 1'b0;
         end
         if (wr_en && index == IDX_CONTROL && wr_byte[CTL_CAPTURE_BIT]) begin
            cap_req_reg <= 1'b1;
         end else if (cap_done) begin
            cap_req_reg <= 1'b0;
         end
      end
   end

   // transfers happen on an oscillator tick so the counter never moves mid copy
   assign set_done = (op_reg == OP_SET) && rtc_tick;
   assign cap_done = (op_reg == OP_CAPTURE) && rtc_tick;

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         op_reg <= OP_IDLE;
      end else begin
         case (op_reg)
            OP_IDLE: begin
               if (set_req_reg) begin
                  op_reg <= OP_SET;
               end else if (cap_req_reg) begin
                  op_reg <= OP_CAPTURE;
               end
            end
            OP_SET: begin
               if (rtc_tick) begin
                  op_reg <= OP_IDLE;
               end
            end
            OP_CAPTURE: begin
               if (rtc_tick) begin
                  op_reg <= OP_IDLE;
               end
            end
            default: begin
               op_reg <= OP_IDLE;
            end
         endcase
      end
   end

   // =========================================================
   // counter; a load takes precedence over counting and auto reset
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         counter_reg <= COUNTER_RESET;
      end else if (set_done) begin
         counter_reg <= {capture_reg[3], capture_reg[2],
            capture_reg[1], capture_reg[0]};
      end else if (alarm_rise && auto_reset_reg) begin
         counter_reg <= COUNTER_RESET;
      end else if (rtc_tick) begin
         counter_reg <= counter_reg + 32'h0000_0001;
      end
   end

   assign COUNTER_O = counter_reg;

   // capture bytes change only by software or by a capture
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         for (int i = 0; i < 4; i++) begin
            capture_reg[i] <= 8'h00;
         end
      end else if (cap_done) begin
         for (int i = 0; i < 4; i++) begin
            capture_reg[i] <= counter_reg[8*i +: 8];
         end
      end else if (wr_en && index <= IDX_CAPTURE3) begin
         capture_reg[index[1:0]] <= wr_byte;
      end
   end

   // =========================================================
   // oscillator control; bits 3:0 have no storage
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         gain_reg <= OSC_FIELD_RESET;
         crystal_reg <= OSC_FIELD_RESET;
         bias_reg <= OSC_FIELD_RESET;
      end else if (wr_en && index == IDX_OSC_CONTROL) begin
         gain_reg <= wr_byte[OSC_GAIN_BIT];
         crystal_reg <= wr_byte[OSC_CRYSTAL_BIT];
         bias_reg <= wr_byte[OSC_BIAS_BIT];
      end
   end

   assign GAIN_CONTROL_ENABLE_O = gain_reg;
   assign CRYSTAL_MODE_SELECT_O = crystal_reg;
   assign BIAS_DOUBLE_ENABLE_O = bias_reg;

   // =========================================================
   // load capacitance configuration; bits 5:4 have no storage
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         step_en_reg <= CFG_STEP_RESET;
         target_reg <= CAP_CODE_RESET;
      end else if (wr_en && index == IDX_OSC_LOAD_CONFIG) begin
         step_en_reg <= wr_byte[CFG_STEP_BIT];
         target_reg <= wr_byte[CFG_CODE_LSB +: 4];
      end
   end

   assign cap_bus.step_enable = step_en_reg;
   assign cap_bus.target_code = target_reg;
   assign cap_bus.rtc_tick = rtc_tick;
   assign LOAD_CAP_CODE_O = cap_bus.applied_code;

   cap_stepper u_stepper (
      .clk_i(CORE_CLK_I),
      .reset_n_i(RESET_N_I),
      .bus(cap_bus.stepper)
   );

   // =========================================================
   // interrupts; a new event wins over a clear in the same cycle
   assign irq_event = {cap_bus.ready && !ready_prev_reg, cap_done, set_done, alarm_rise};
   assign irq_clear = (wr_en && index == IDX_IRQ_CLEAR) ? wr_byte[IRQ_WIDTH-1:0] : IRQ_RESET;

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         ready_prev_reg <= 1'b1;
         irq_status_reg <= IRQ_RESET;
      end else begin
         ready_prev_reg <= cap_bus.ready;
         irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         irq_enable_reg <= IRQ_RESET;
      end else if (wr_en && index == IDX_IRQ_ENABLE) begin
         irq_enable_reg <= wr_byte[IRQ_WIDTH-1:0];
      end
   end

   assign IRQ_O = |(irq_status_reg & irq_enable_reg);
endmodule
`default_nettype wire

/* verif/rtc_osc_chk.sv */
// checker for the oscillator control and status block
`timescale 1ns/1ps
`default_nettype none
module rtc_osc_chk
   import rtc_osc_pkg::*;
(
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   input wire logic [7:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire rtc_osc_pkg::word_type AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   input wire rtc_osc_pkg::word_type AVS_READDATA_O,
   input wire logic AVS_WAITREQUEST_O,
   input wire logic RTC_CLK_I,
   input wire logic ALARM_MATCH_I,
   input wire logic AMP_VALID_I,
   input wire logic GAIN_CONTROL_ENABLE_O,
   input wire logic CRYSTAL_MODE_SELECT_O,
   input wire logic BIAS_DOUBLE_ENABLE_O,
   input wire rtc_osc_pkg::cap_code_type LOAD_CAP_CODE_O,
   input wire rtc_osc_pkg::word_type COUNTER_O,
   input wire logic IRQ_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   logic req, done, osc_wr, cfg_wr, cfg_rd, step_en_reg;
   cap_code_type target_reg;
   // ==========================================================
   // shadow of the config register, so readback can be judged
   assign req = AVS_READ_I | AVS_WRITE_I;
   assign done = req & !AVS_WAITREQUEST_O;
   assign osc_wr = done & AVS_WRITE_I & AVS_BYTEENABLE_I[0]
      & AVS_ADDRESS_I[7:2] == IDX_OSC_CONTROL;
   assign cfg_wr = done & AVS_WRITE_I & AVS_BYTEENABLE_I[0]
      & AVS_ADDRESS_I[7:2] == IDX_OSC_LOAD_CONFIG;
   assign cfg_rd = done & AVS_READ_I & AVS_ADDRESS_I[7:2] == IDX_OSC_LOAD_CONFIG;
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         step_en_reg <= CFG_STEP_RESET;
         target_reg <= CAP_CODE_RESET;
      end else if (cfg_wr) begin
         step_en_reg <= AVS_WRITEDATA_I[CFG_STEP_BIT];
         target_reg <= AVS_WRITEDATA_I[3:0];
      end
   end
   // ==========================================================
   // assertions
   wait_first_a: assert property ($rose(req) |-> AVS_WAITREQUEST_O)
      else $error("request start without wait cycle");
   wait_one_a: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
      else $error("more than one wait cycle");
   gain_write_a: assert property (
      osc_wr |=> GAIN_CONTROL_ENABLE_O == $past(AVS_WRITEDATA_I[OSC_GAIN_BIT]))
      else $error("gain control output wrong");
   crystal_write_a: assert property (
      osc_wr |=> CRYSTAL_MODE_SELECT_O == $past(AVS_WRITEDATA_I[OSC_CRYSTAL_BIT]))
      else $error("crystal mode output wrong");
   bias_write_a: assert property (
      osc_wr |=> BIAS_DOUBLE_ENABLE_O == $past(AVS_WRITEDATA_I[OSC_BIAS_BIT]))
      else $error("bias double output wrong");
   osc_unused_a: assert property (
      done && AVS_READ_I && AVS_ADDRESS_I[7:2] == IDX_OSC_CONTROL
      |-> AVS_READDATA_O[3:0] == 4'h0 && AVS_READDATA_O[31:8] == 24'h0)
      else $error("unused oscillator bits not zero");
   cfg_read_a: assert property (cfg_rd |-> AVS_READDATA_O == {24'h0, $past(step_en_reg),
      $past(LOAD_CAP_CODE_O) == $past(target_reg), 2'b00, $past(target_reg)})
      else $error("config readback wrong");
   step_size_a: assert property (step_en_reg && $past(step_en_reg)
      |-> 4'(LOAD_CAP_CODE_O - $past(LOAD_CAP_CODE_O)) inside {4'h0, 4'h1, 4'hf})
      else $error("capacitance moved more than one step");
   step_off_a: assert property (!step_en_reg && !$past(step_en_reg)
      |-> LOAD_CAP_CODE_O == $past(target_reg))
      else $error("capacitance not at target with stepping off");
   cover property (osc_wr);
   cover property (cfg_rd && !AVS_READDATA_O[CFG_READY_BIT]);
   cover property (step_en_reg && $changed(LOAD_CAP_CODE_O));
   cover property ($rose(IRQ_O));
endmodule
bind rtc_osc_control_status rtc_osc_chk chk (.CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I),
   .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
   .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
   .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
   .RTC_CLK_I(RTC_CLK_I), .ALARM_MATCH_I(ALARM_MATCH_I), .AMP_VALID_I(AMP_VALID_I),
   .GAIN_CONTROL_ENABLE_O(GAIN_CONTROL_ENABLE_O), .CRYSTAL_MODE_SELECT_O(CRYSTAL_MODE_SELECT_O),
   .BIAS_DOUBLE_ENABLE_O(BIAS_DOUBLE_ENABLE_O), .LOAD_CAP_CODE_O(LOAD_CAP_CODE_O),
   .COUNTER_O(COUNTER_O), .IRQ_O(IRQ_O));
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the oscillator control and status block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rtc_osc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   word_type wdata = 32'h0;
   logic [3:0] be = 4'h0;
   logic rtc_clk = 1'b0;
   logic alarm = 1'b0;
   logic amp = 1'b0;
   word_type rdata, counter;
   logic waitreq, gain, crystal, bias, irq;
   cap_code_type cap_code;
   int failures = 0;
   int num_checks = 0;
   rtc_osc_control_status dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .AVS_ADDRESS_I(addr),
      .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
      .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .RTC_CLK_I(rtc_clk),
      .ALARM_MATCH_I(alarm), .AMP_VALID_I(amp), .GAIN_CONTROL_ENABLE_O(gain),
      .CRYSTAL_MODE_SELECT_O(crystal), .BIAS_DOUBLE_ENABLE_O(bias), .LOAD_CAP_CODE_O(cap_code),
      .COUNTER_O(counter), .IRQ_O(irq));
   always #12.5 clk = ~clk;
   // ==========================================================
   // helpers
   task automatic chk(input string name, input word_type exp, input word_type got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one edge of idle after each access, so no signal is driven twice in a step
   task automatic bus(input logic w, input logic [5:0] idx, input word_type d,
      input logic [3:0] en, output word_type q);
      int n;
      n = 0;
      addr <= {idx, 2'b00};
      wdata <= d;
      be <= en;
      rd_en <= !w;
      wr_en <= w;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      q = rdata;
      if (waitreq !== 1'b0) failures++;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [5:0] idx, input byte_type d);
      word_type q;
      bus(1'b1, idx, {24'h0, d}, 4'h1, q);
   endtask
   task automatic rd(input logic [5:0] idx, output word_type q);
      bus(1'b0, idx, 32'h0, 4'h1, q);
   endtask
   // one oscillator cycle; the pin stays low between ticks
   task automatic tick();
      rtc_clk <= 1'b1;
      repeat (6) @(posedge clk);
      rtc_clk <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   function automatic word_type osc_exp(byte_type d, logic a);
      return {24'h0, d[7:5], a, 4'h0};
   endfunction
   function automatic word_type cfg_exp(logic s, cap_code_type t, logic r);
      return {24'h0, s, r, 2'b00, t};
   endfunction
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      wrap_up();
   end
   // ==========================================================
   // tests
   initial begin
      word_type q, w, w2;
      byte_type d;
      cap_code_type c, c2, e;
      void'($urandom(55049));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(IDX_OSC_CONTROL, q);
      chk("osc_control reset", 32'h0, q);
      rd(IDX_OSC_LOAD_CONFIG, q);
      chk("config reset", cfg_exp(CFG_STEP_RESET, CAP_CODE_RESET, 1'b1), q);
      rd(6'h3f, q);
      chk("unmapped read", 32'h0, q);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'hff : byte_type'($urandom);
         amp <= d[0];
         wr(IDX_OSC_CONTROL, d);
         repeat (4) @(posedge clk);
         rd(IDX_OSC_CONTROL, q);
         chk("osc_control", osc_exp(d, d[0]), q);
         chk("osc pins", {29'h0, d[7:5]}, {29'h0, gain, crystal, bias});
      end
      bus(1'b1, IDX_OSC_CONTROL, 32'h0, 4'h0, q);
      rd(IDX_OSC_CONTROL, q);
      chk("osc no byte enable", osc_exp(d, d[0]), q);
      $display("test oscillator done");
      c = cap_code_type'($urandom);
      c2 = c + cap_code_type'(1 + $urandom % 15);
      wr(IDX_OSC_LOAD_CONFIG, {4'h3, c});
      rd(IDX_OSC_LOAD_CONFIG, q);
      chk("config direct", cfg_exp(1'b0, c, 1'b1), q);
      chk("applied direct", {28'h0, c}, {28'h0, cap_code});
      wr(IDX_IRQ_CLEAR, 8'h0f);
      wr(IDX_IRQ_ENABLE, 8'h08);
      wr(IDX_OSC_LOAD_CONFIG, {4'hb, c2});
      rd(IDX_OSC_LOAD_CONFIG, q);
      chk("config stepping", cfg_exp(1'b1, c2, 1'b0), q);
      e = c;
      while (e != c2) begin
         tick();
         e = (e < c2) ? e + 4'h1 : e - 4'h1;
         chk("applied step", {28'h0, e}, {28'h0, cap_code});
      end
      rd(IDX_OSC_LOAD_CONFIG, q);
      chk("config ready", cfg_exp(1'b1, c2, 1'b1), q);
      chk("ready irq", 32'h1, {31'h0, irq});
      wr(IDX_IRQ_CLEAR, 8'h08);
      chk("ready irq cleared", 32'h0, {31'h0, irq});
      $display("test stepping done");
      w = $urandom;
      for (int i = 0; i < 4; i++) wr(IDX_CAPTURE0 + 6'(i), w[8*i +: 8]);
      wr(IDX_CONTROL, 8'h02);
      rd(IDX_CONTROL, q);
      chk("set pending", 32'h2, q & 32'h3);
      tick();
      rd(IDX_CONTROL, q);
      chk("set done", 32'h0, q & 32'h3);
      chk("counter loaded", w, counter);
      wr(IDX_CONTROL, 8'h01);
      rd(IDX_CONTROL, q);
      chk("capture pending", 32'h1, q & 32'h3);
      tick();
      rd(IDX_CONTROL, q);
      chk("capture done", 32'h0, q & 32'h3);
      for (int i = 0; i < 4; i++) begin
         rd(IDX_CAPTURE0 + 6'(i), q);
         w2[8*i +: 8] = q[7:0];
      end
      // the copy takes the counter as it stood before that tick's increment
      chk("capture image", w, w2);
      rd(IDX_IRQ_STATUS, q);
      chk("timer done status", 32'h6, q & 32'h6);
      $display("test timer done");
      wr(IDX_IRQ_CLEAR, 8'h0f);
      wr(IDX_IRQ_ENABLE, 8'h01);
      wr(IDX_CONTROL, 8'h04);
      alarm <= 1'b1;
      repeat (6) @(posedge clk);
      rd(IDX_CONTROL, q);
      chk("alarm flag", 32'h4, q);
      chk("auto reset", 32'h0, counter);
      chk("alarm irq", 32'h1, {31'h0, irq});
      wr(IDX_CONTROL, 8'h00);
      rd(IDX_CONTROL, q);
      chk("flag after write", 32'h4, q);
      tick();
      rd(IDX_CONTROL, q);
      chk("flag after tick", 32'h0, q);
      rd(IDX_IRQ_STATUS, q);
      chk("alarm status", 32'h1, q & 32'h1);
      wr(IDX_IRQ_ENABLE, 8'h00);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(IDX_IRQ_CLEAR, 8'h01);
      wr(IDX_IRQ_ENABLE, 8'h01);
      chk("irq cleared", 32'h0, {31'h0, irq});
      alarm <= 1'b0;
      $display("test alarm done");
      wrap_up();
   end
endmodule
`default_nettype wire
